//--- inc/ramp_pkg.sv
// Constants, register map and helpers for the automatic ramp generator.
// Assumes the ramp clock is the phase-detector clock of the synthesizer.
package ramp_pkg;
	localparam int STEP_W  = 30;
	localparam int OFS_W   = 33;
	localparam int LEN_W   = 17;
	localparam int PCNT_W  = 16;
	localparam int SCALE_W = 4;
	localparam int DIV_W   = 2;
	localparam int TGT_W   = 31;

	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] LIM_HI_OFS  = 8'h04;
	localparam logic [7:0] LIM_LO_OFS  = 8'h08;
	localparam logic [7:0] LIM_MSB_OFS = 8'h0c;
	localparam logic [7:0] THRESH_OFS  = 8'h10;
	localparam logic [7:0] STEP0_OFS   = 8'h14;
	localparam logic [7:0] STEP1_OFS   = 8'h18;
	localparam logic [7:0] CFG0_OFS    = 8'h1c;
	localparam logic [7:0] CFG1_OFS    = 8'h20;
	localparam logic [7:0] STATUS_OFS  = 8'h24;
	localparam logic [7:0] OFFSET_OFS  = 8'h28;

	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_MAN_BIT   = 1;
	localparam int CTRL_DIV_LSB   = 4;
	localparam int CTRL_SCALE_LSB = 8;
	localparam int CTRL_PCNT_LSB  = 16;
	localparam int CFG_LEN_LSB    = 0;
	localparam int CFG_HALF_BIT   = 17;
	localparam int CFG_SUCC_BIT   = 18;
	localparam int CFG_TRIG_BIT   = 19;
	localparam int CFG_RST_BIT    = 20;
	localparam int CFG_W          = 21;

	localparam logic [31:0]     WORD_RST = 32'h0000_0000;
	localparam logic [OFS_W-1:0] OFS_RST = 33'h0_0000_0000;
	localparam logic [LEN_W-1:0] LEN_RST = 17'h0_0000;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_WAIT} ramp_state_t;

	function automatic logic [OFS_W-1:0] step_ext(input logic [STEP_W-1:0] s);
		return {{(OFS_W-STEP_W){s[STEP_W-1]}}, s};
	endfunction : step_ext

	function automatic logic [OFS_W-1:0] abs_diff(input logic [OFS_W-1:0] a,
		input logic [OFS_W-1:0] b);
		logic [OFS_W-1:0] d;
		d = a - b;
		return d[OFS_W-1] ? (~d + 33'h0_0000_0001) : d;
	endfunction : abs_diff
endpackage : ramp_pkg

//--- design/sm_tick.sv
// Calibration state-machine clock as a tick: one pulse per 2^div clocks.
// Assumes the block clock stands for the reference input.
`timescale 1ns/10ps
`default_nettype none
module sm_tick (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [ramp_pkg::DIV_W-1:0] div,
	output logic                          tick
);
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic [2:0] mask;

	always_comb begin
		mask = (3'h1 << div) - 3'h1;
		tick = (cnt_reg & mask) == mask;
		cnt_next = tick ? 3'h0 : cnt_reg + 3'h1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule : sm_tick
`default_nettype wire

//--- design/pause_timer.sv
// Minimum pause timer counting state-machine ticks.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module pause_timer (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        start,
	input  wire logic                        tick,
	input  wire logic [ramp_pkg::PCNT_W-1:0]  count,
	input  wire logic [ramp_pkg::SCALE_W-1:0] scale,
	output logic                             busy
);
	logic [ramp_pkg::TGT_W-1:0] left_reg;
	logic [ramp_pkg::TGT_W-1:0] left_next;
	logic                       busy_reg;
	logic                       busy_next;

	always_comb begin
		left_next = left_reg;
		busy_next = busy_reg;
		if (start) begin
			left_next = ramp_pkg::TGT_W'({15'h0, count} << scale);
			busy_next = 1'b1;
		end else if (busy_reg && tick) begin
			if (left_reg <= 31'h0000_0001) begin
				busy_next = 1'b0;
			end else begin
				left_next = left_reg - 31'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			left_reg <= 31'h0000_0000;
			busy_reg <= 1'b0;
		end else begin
			left_reg <= left_next;
			busy_reg <= busy_next;
		end
	end

	assign busy = busy_reg;
endmodule : pause_timer
`default_nettype wire

//--- design/ramp_gen.sv
// Automatic frequency ramp generator with AHB-Lite register slave.
// Assumes CLK is the phase-detector clock and CAL_BUSY comes from the
// VCO calibration engine on the same clock.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ramp_gen (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        TRIG,
	input  wire logic        CAL_BUSY,
	output logic             CAL_START,
	output logic      [32:0] RAMP_OFFSET,
	output logic             RAMP_ACTIVE
);
	// Bus slave
	logic [7:0]  addr_reg;
	logic [7:0]  addr_next;
	logic        wr_pend_reg;
	logic        wr_pend_next;
	logic        rd_pend_reg;
	logic        rd_pend_next;
	logic        ready_reg;
	logic        ready_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] rd_word;
	logic        take;

	// Registers
	logic [31:0]                  ctrl_reg;
	logic [31:0]                  ctrl_next;
	logic [31:0]                  lim_hi_reg;
	logic [31:0]                  lim_hi_next;
	logic [31:0]                  lim_lo_reg;
	logic [31:0]                  lim_lo_next;
	logic [1:0]                   lim_msb_reg;
	logic [1:0]                   lim_msb_next;
	logic [ramp_pkg::STEP_W-1:0]  thresh_reg;
	logic [ramp_pkg::STEP_W-1:0]  thresh_next;
	logic [ramp_pkg::STEP_W-1:0]  step_reg [2];
	logic [ramp_pkg::STEP_W-1:0]  step_next [2];
	logic [ramp_pkg::CFG_W-1:0]   cfg_reg [2];
	logic [ramp_pkg::CFG_W-1:0]   cfg_next [2];

	// Engine
	ramp_pkg::ramp_state_t       state_reg;
	ramp_pkg::ramp_state_t       state_next;
	logic                        prof_reg;
	logic                        prof_next;
	logic [ramp_pkg::LEN_W-1:0]  cnt_reg;
	logic [ramp_pkg::LEN_W-1:0]  cnt_next;
	logic                        phase_reg;
	logic                        phase_next;
	logic [ramp_pkg::OFS_W-1:0]  offset_reg;
	logic [ramp_pkg::OFS_W-1:0]  offset_next;
	logic [ramp_pkg::OFS_W-1:0]  base_reg;
	logic [ramp_pkg::OFS_W-1:0]  base_next;
	logic                        cal_start_reg;
	logic                        cal_start_next;
	logic                        active_reg;
	logic                        active_next;
	logic [2:0]                  trig_sync_reg;
	logic [2:0]                  trig_sync_next;

	logic                        auto_on;
	logic [ramp_pkg::CFG_W-1:0]  cfg;
	logic [ramp_pkg::OFS_W-1:0]  lim_hi;
	logic [ramp_pkg::OFS_W-1:0]  lim_lo;
	logic [ramp_pkg::OFS_W-1:0]  sum_c;
	logic                        prof_end;
	logic                        step_ok;
	logic                        hit;
	logic                        trig_rise;
	logic                        tick;
	logic                        pause_busy;
	logic                        pause_go;

	assign take = HSEL && HTRANS[1] && HREADY;

	always_comb begin
		case (addr_reg)
			ramp_pkg::CTRL_OFS:    rd_word = ctrl_reg;
			ramp_pkg::LIM_HI_OFS:  rd_word = lim_hi_reg;
			ramp_pkg::LIM_LO_OFS:  rd_word = lim_lo_reg;
			ramp_pkg::LIM_MSB_OFS: rd_word = {30'h0, lim_msb_reg};
			ramp_pkg::THRESH_OFS:  rd_word = {2'h0, thresh_reg};
			ramp_pkg::STEP0_OFS:   rd_word = {2'h0, step_reg[0]};
			ramp_pkg::STEP1_OFS:   rd_word = {2'h0, step_reg[1]};
			ramp_pkg::CFG0_OFS:    rd_word = {11'h0, cfg_reg[0]};
			ramp_pkg::CFG1_OFS:    rd_word = {11'h0, cfg_reg[1]};
			ramp_pkg::STATUS_OFS:  rd_word = {6'h0, cnt_reg, 4'h0,
				offset_reg[32], pause_busy, prof_reg, 2'(state_reg)};
			ramp_pkg::OFFSET_OFS:  rd_word = offset_reg[31:0];
			default:               rd_word = ramp_pkg::WORD_RST;
		endcase
	end

	// Reads take one wait state so read data always come from a flop
	always_comb begin
		addr_next = take ? HADDR[7:0] : addr_reg;
		wr_pend_next = take && HWRITE;
		rd_pend_next = take && !HWRITE;
		ready_next = !(take && !HWRITE);
		rdata_next = rd_pend_reg ? rd_word : rdata_reg;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			addr_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			ready_reg <= 1'b1;
			rdata_reg <= ramp_pkg::WORD_RST;
		end else begin
			addr_reg <= addr_next;
			wr_pend_reg <= wr_pend_next;
			rd_pend_reg <= rd_pend_next;
			ready_reg <= ready_next;
			rdata_reg <= rdata_next;
		end
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		lim_hi_next = lim_hi_reg;
		lim_lo_next = lim_lo_reg;
		lim_msb_next = lim_msb_reg;
		thresh_next = thresh_reg;
		step_next = step_reg;
		cfg_next = cfg_reg;
		if (wr_pend_reg && HREADY) begin
			case (addr_reg)
				ramp_pkg::CTRL_OFS:    ctrl_next = HWDATA;
				ramp_pkg::LIM_HI_OFS:  lim_hi_next = HWDATA;
				ramp_pkg::LIM_LO_OFS:  lim_lo_next = HWDATA;
				ramp_pkg::LIM_MSB_OFS: lim_msb_next = HWDATA[1:0];
				ramp_pkg::THRESH_OFS:  thresh_next = HWDATA[29:0];
				ramp_pkg::STEP0_OFS:   step_next[0] = HWDATA[29:0];
				ramp_pkg::STEP1_OFS:   step_next[1] = HWDATA[29:0];
				ramp_pkg::CFG0_OFS:    cfg_next[0] = HWDATA[20:0];
				ramp_pkg::CFG1_OFS:    cfg_next[1] = HWDATA[20:0];
				default:               ctrl_next = ctrl_reg;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_reg <= ramp_pkg::WORD_RST;
			lim_hi_reg <= ramp_pkg::WORD_RST;
			lim_lo_reg <= ramp_pkg::WORD_RST;
			lim_msb_reg <= 2'h0;
			thresh_reg <= 30'h0000_0000;
			step_reg <= '{30'h0000_0000, 30'h0000_0000};
			cfg_reg <= '{21'h00_0000, 21'h00_0000};
		end else begin
			ctrl_reg <= ctrl_next;
			lim_hi_reg <= lim_hi_next;
			lim_lo_reg <= lim_lo_next;
			lim_msb_reg <= lim_msb_next;
			thresh_reg <= thresh_next;
			step_reg <= step_next;
			cfg_reg <= cfg_next;
		end
	end

	sm_tick u_tick (
		.clk  (CLK),
		.rst  (RST),
		.div  (ctrl_reg[ramp_pkg::CTRL_DIV_LSB +: ramp_pkg::DIV_W]),
		.tick (tick)
	);

	pause_timer u_pause (
		.clk   (CLK),
		.rst   (RST),
		.start (pause_go),
		.tick  (tick),
		.count (ctrl_reg[ramp_pkg::CTRL_PCNT_LSB +: ramp_pkg::PCNT_W]),
		.scale (ctrl_reg[ramp_pkg::CTRL_SCALE_LSB +: ramp_pkg::SCALE_W]),
		.busy  (pause_busy)
	);

	assign auto_on = ctrl_reg[ramp_pkg::CTRL_EN_BIT]
		&& !ctrl_reg[ramp_pkg::CTRL_MAN_BIT];
	assign cfg = cfg_reg[prof_reg];
	assign lim_hi = {lim_msb_reg[0], lim_hi_reg};
	assign lim_lo = {lim_msb_reg[1], lim_lo_reg};
	assign prof_end = cnt_reg >= cfg[ramp_pkg::CFG_LEN_LSB +: ramp_pkg::LEN_W];
	assign step_ok = !cfg[ramp_pkg::CFG_HALF_BIT] || phase_reg;
	assign trig_rise = trig_sync_reg[1] && !trig_sync_reg[2];

	always_comb begin
		sum_c = offset_reg + ramp_pkg::step_ext(step_reg[prof_reg]);
		if ($signed(sum_c) > $signed(lim_hi)) begin
			sum_c = lim_hi;
		end else if ($signed(sum_c) < $signed(lim_lo)) begin
			sum_c = lim_lo;
		end
		hit = ramp_pkg::abs_diff(sum_c, base_reg) > {3'h0, thresh_reg};
	end

	always_comb begin
		state_next = state_reg;
		prof_next = prof_reg;
		cnt_next = cnt_reg;
		phase_next = phase_reg;
		offset_next = offset_reg;
		base_next = base_reg;
		cal_start_next = 1'b0;
		pause_go = 1'b0;
		trig_sync_next = {trig_sync_reg[1:0], TRIG};
		case (state_reg)
			ramp_pkg::ST_IDLE: begin
				if (auto_on) begin
					state_next = ramp_pkg::ST_RUN;
					prof_next = 1'b0;
					cnt_next = ramp_pkg::LEN_RST;
					phase_next = 1'b0;
					offset_next = ramp_pkg::OFS_RST;
					base_next = ramp_pkg::OFS_RST;
				end
			end
			ramp_pkg::ST_RUN: begin
				if (prof_end) begin
					if (cfg[ramp_pkg::CFG_RST_BIT]) begin
						offset_next = ramp_pkg::OFS_RST;
						base_next = ramp_pkg::OFS_RST;
					end
					prof_next = cfg[ramp_pkg::CFG_SUCC_BIT];
					cnt_next = ramp_pkg::LEN_RST;
					phase_next = 1'b0;
					if (cfg[ramp_pkg::CFG_TRIG_BIT]) begin
						state_next = ramp_pkg::ST_WAIT;
					end
				end else begin
					phase_next = !phase_reg;
					if (step_ok) begin
						offset_next = sum_c;
						cnt_next = cnt_reg + 17'h0_0001;
						if (hit) begin
							base_next = sum_c;
							cal_start_next = 1'b1;
							pause_go = 1'b1;
							state_next = ramp_pkg::ST_PAUSE;
						end
					end
				end
			end
			ramp_pkg::ST_PAUSE: begin
				if (!pause_busy && !cal_start_reg && !CAL_BUSY) begin
					state_next = ramp_pkg::ST_RUN;
				end
			end
			ramp_pkg::ST_WAIT: begin
				if (trig_rise) begin
					state_next = ramp_pkg::ST_RUN;
				end
			end
			default: state_next = ramp_pkg::ST_IDLE;
		endcase
		if (!auto_on) begin
			state_next = ramp_pkg::ST_IDLE;
		end
		active_next = state_next != ramp_pkg::ST_IDLE;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_reg <= ramp_pkg::ST_IDLE;
			prof_reg <= 1'b0;
			cnt_reg <= ramp_pkg::LEN_RST;
			phase_reg <= 1'b0;
			offset_reg <= ramp_pkg::OFS_RST;
			base_reg <= ramp_pkg::OFS_RST;
			cal_start_reg <= 1'b0;
			active_reg <= 1'b0;
			trig_sync_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			prof_reg <= prof_next;
			cnt_reg <= cnt_next;
			phase_reg <= phase_next;
			offset_reg <= offset_next;
			base_reg <= base_next;
			cal_start_reg <= cal_start_next;
			active_reg <= active_next;
			trig_sync_reg <= trig_sync_next;
		end
	end

	assign HRDATA = rdata_reg;
	assign HREADYOUT = ready_reg;
	assign HRESP = 1'b0;
	assign CAL_START = cal_start_reg;
	assign RAMP_OFFSET = offset_reg;
	assign RAMP_ACTIVE = active_reg;

	auto_off_a: assert property (@(posedge CLK) disable iff (RST)
		!auto_on |=> state_reg == ramp_pkg::ST_IDLE)
		else $error("ramp not idle while disabled");
	step_rate_a: assert property (@(posedge CLK) disable iff (RST)
		(auto_on && state_reg == ramp_pkg::ST_RUN && !prof_end && step_ok)
		|=> offset_reg == $past(sum_c))
		else $error("step not applied");
	half_rate_a: assert property (@(posedge CLK) disable iff (RST)
		(auto_on && state_reg == ramp_pkg::ST_RUN && !prof_end && !step_ok)
		|=> $stable(offset_reg) ##1 (state_reg != ramp_pkg::ST_RUN
		|| offset_reg != $past(offset_reg) || prof_end || !auto_on
		|| $past(sum_c) == $past(offset_reg)))
		else $error("half rate stepping wrong");
	upper_lim_a: assert property (@(posedge CLK) disable iff (RST)
		(state_reg == ramp_pkg::ST_RUN && step_ok && !prof_end
		&& $signed(lim_lo) <= $signed(lim_hi) && auto_on)
		|=> $signed(offset_reg) <= $signed($past(lim_hi)))
		else $error("offset above upper limit");
	lower_lim_a: assert property (@(posedge CLK) disable iff (RST)
		(state_reg == ramp_pkg::ST_RUN && step_ok && !prof_end
		&& $signed(lim_lo) <= $signed(lim_hi) && auto_on)
		|=> $signed(offset_reg) >= $signed($past(lim_lo)))
		else $error("offset below lower limit");
	cal_hit_a: assert property (@(posedge CLK) disable iff (RST)
		(auto_on && state_reg == ramp_pkg::ST_RUN && !prof_end && step_ok
		&& hit) |=> CAL_START && state_reg == ramp_pkg::ST_PAUSE ##1 !CAL_START)
		else $error("threshold hit without calibration");
	hold_pause_a: assert property (@(posedge CLK) disable iff (RST)
		state_reg == ramp_pkg::ST_PAUSE |=> $stable(offset_reg))
		else $error("offset moved during pause");
	pause_ext_a: assert property (@(posedge CLK) disable iff (RST)
		(state_reg == ramp_pkg::ST_PAUSE && auto_on
		&& (CAL_BUSY || pause_busy)) |=> state_reg == ramp_pkg::ST_PAUSE)
		else $error("pause ended early");
	successor_a: assert property (@(posedge CLK) disable iff (RST)
		(auto_on && state_reg == ramp_pkg::ST_RUN && prof_end)
		|=> prof_reg == $past(cfg[ramp_pkg::CFG_SUCC_BIT])
		&& cnt_reg == ramp_pkg::LEN_RST)
		else $error("wrong successor profile");
	immediate_a: assert property (@(posedge CLK) disable iff (RST)
		(auto_on && state_reg == ramp_pkg::ST_RUN && prof_end
		&& !cfg[ramp_pkg::CFG_TRIG_BIT]) |=> state_reg == ramp_pkg::ST_RUN)
		else $error("successor not started at once");
	restart_a: assert property (@(posedge CLK) disable iff (RST)
		(auto_on && state_reg == ramp_pkg::ST_RUN && prof_end
		&& cfg[ramp_pkg::CFG_RST_BIT]) |=> offset_reg == ramp_pkg::OFS_RST)
		else $error("restart did not reload start");
endmodule : ramp_gen
`default_nettype wire

//--- tb/tb_top.sv
// Testbench for the ramp generator: registers, profiles, limits, pauses.
// Assumes one AHB-Lite slave, so HREADY is fed back from HREADYOUT.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct {logic [32:0] ofs; int gap;} ofs_note_t;
	localparam int P_CNT     = 2;
	localparam int P_SCALE   = 1;
	localparam int P_DIV     = 1;
	localparam int PAUSE_MIN = (P_CNT << P_SCALE << P_DIV) + 1;
	localparam logic [7:0] MAP [12] = '{ramp_pkg::CTRL_OFS,
		ramp_pkg::LIM_HI_OFS, ramp_pkg::LIM_LO_OFS, ramp_pkg::LIM_MSB_OFS,
		ramp_pkg::THRESH_OFS, ramp_pkg::STEP0_OFS, ramp_pkg::STEP1_OFS,
		ramp_pkg::CFG0_OFS, ramp_pkg::CFG1_OFS, ramp_pkg::STATUS_OFS,
		ramp_pkg::OFFSET_OFS, 8'h30};
	localparam logic [31:0] MSK [12] = '{32'hffffffff, 32'hffffffff,
		32'hffffffff, 32'h00000003, 32'h3fffffff, 32'h3fffffff,
		32'h3fffffff, 32'h001fffff, 32'h001fffff, 32'h0, 32'h0, 32'h0};
	logic        CLK      = 1'b0;
	logic        RST      = 1'b1;
	logic        HSEL     = 1'b0;
	logic [31:0] HADDR    = 32'h0;
	logic [1:0]  HTRANS   = 2'h0;
	logic        HWRITE   = 1'b0;
	logic [2:0]  HSIZE    = 3'h2;
	logic [31:0] HWDATA   = 32'h0;
	logic        TRIG     = 1'b0;
	logic        CAL_BUSY = 1'b0;
	wire  [31:0] HRDATA;
	wire         HREADYOUT;
	wire         HRESP;
	wire         CAL_START;
	wire  [32:0] RAMP_OFFSET;
	wire         RAMP_ACTIVE;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          last_chg = 0;
	int          cal_n = 0;
	logic [32:0] prev_ofs = 33'h0;
	logic        rd_phase = 1'b0;
	logic [31:0] rnd = 32'h79777676;
	logic [31:0] exp_rd[$];
	ofs_note_t   exp_ofs[$];
	ofs_note_t   note;

	ramp_gen u_dut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .TRIG(TRIG), .CAL_BUSY(CAL_BUSY),
		.CAL_START(CAL_START), .RAMP_OFFSET(RAMP_OFFSET),
		.RAMP_ACTIVE(RAMP_ACTIVE));

	always #5 CLK = ~CLK;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [31:0] cfg(input int len, half, succ, rs);
		return (len << ramp_pkg::CFG_LEN_LSB) | (half << ramp_pkg::CFG_HALF_BIT)
			| (succ << ramp_pkg::CFG_SUCC_BIT) | (rs << ramp_pkg::CFG_RST_BIT);
	endfunction : cfg

	task automatic fail(input string msg);
		n_mismatch++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask : fail

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) fail($sformatf("read %h, expected %h", got, exp));
	endtask : cmp_rd

	task automatic cmp_ofs(input logic [32:0] got, input logic [32:0] exp,
		input int gap, input int egap);
		checks_done++;
		if (got !== exp || (egap != 0 && gap != egap))
			fail($sformatf("offset %h after %0d, expected %h after %0d",
				got, gap, exp, egap));
	endtask : cmp_ofs

	task automatic cmp_flag(input logic got, input string what);
		checks_done++;
		if (got !== 1'b1) fail(what);
	endtask : cmp_flag

	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail("bus answer missing");
			stop_test();
		end
	endtask : wait_ready

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		HSEL   <= 1'b1;
		HTRANS <= 2'b10;
		HWRITE <= w;
		HADDR  <= {24'h0, a};
		wait_ready();
		HSEL   <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= d;
		wait_ready();
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic do_reset;
		@(posedge CLK);
		RST <= 1'b1;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
	endtask : do_reset

	task automatic push_ofs(input logic [32:0] v, input int g);
		exp_ofs.push_back('{v, g});
	endtask : push_ofs

	task automatic drain(input string name);
		int n;
		n = 0;
		while (exp_ofs.size() > 0 && n < 2000) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 2000) begin
			fail("ramp stalled");
			stop_test();
		end
		$display("test %s finished", name);
	endtask : drain

	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail("run too long");
			stop_test();
		end
	end

	// Result watcher: read data and every offset change
	always @(posedge CLK) begin
		if (HRESP !== 1'b0) fail("error response");
		if (RST) begin
			rd_phase <= 1'b0;
			prev_ofs <= 33'h0;
		end else begin
			if (HREADYOUT === 1'b1) begin
				rd_phase <= HSEL & HTRANS[1] & ~HWRITE;
				if (rd_phase && exp_rd.size() > 0)
					cmp_rd(HRDATA, exp_rd.pop_front());
			end
			if (RAMP_OFFSET !== prev_ofs) begin
				prev_ofs <= RAMP_OFFSET;
				last_chg <= cyc;
				if (exp_ofs.size() > 0) begin
					note = exp_ofs.pop_front();
					cmp_ofs(RAMP_OFFSET, note.ofs, cyc - last_chg, note.gap);
				end
			end
		end
	end

	// Calibration engine stand-in: first run long, later ones short
	initial begin : cal_side
		int          len;
		int          gap;
		logic [32:0] held;
		forever begin
			@(posedge CLK);
			if (CAL_START === 1'b1 && !RST) begin
				cal_n++;
				len = (cal_n == 1) ? 20 : 1;
				held = RAMP_OFFSET;
				CAL_BUSY <= 1'b1;
				gap = 0;
				while (RAMP_OFFSET === held && gap < 300) begin
					@(posedge CLK);
					gap++;
					if (gap == len) CAL_BUSY <= 1'b0;
				end
				if (gap >= 300) begin
					fail("calibration pause stuck");
					stop_test();
				end else begin
					cmp_flag(gap > len && gap >= PAUSE_MIN, "pause too short");
				end
			end
		end
	end

	initial begin : main
		int          i;
		logic [31:0] ctrl;
		int          v2 [10] = '{5, 8, 7, 6, 5, 8, 7, 6, 5, 8};
		int          g2 [10] = '{0, 1, 3, 2, 2, 4, 4, 2, 2, 4};
		int          v3 [7] = '{3, 6, 9, 12, 0, 3, 6};
		int          g3 [7] = '{0, 1, 0, 1, 0, 1, 1};
		ctrl = 32'h1 | (P_DIV << ramp_pkg::CTRL_DIV_LSB)
			| (P_SCALE << ramp_pkg::CTRL_SCALE_LSB)
			| (P_CNT << ramp_pkg::CTRL_PCNT_LSB);
		do_reset();
		for (i = 0; i < 12; i++) rd(MAP[i], 32'h0);
		for (i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			bus(1'b1, MAP[i], rnd & 32'hfffffffe);
			rd(MAP[i], rnd & 32'hfffffffe & MSK[i]);
		end
		bus(1'b1, ramp_pkg::CTRL_OFS, 32'h3);
		repeat (10) @(posedge CLK);
		cmp_flag(RAMP_ACTIVE === 1'b0 && RAMP_OFFSET === 33'h0, "ran in manual");
		rd(ramp_pkg::STATUS_OFS, 32'h0);
		$display("test registers finished");
		do_reset();
		bus(1'b1, ramp_pkg::LIM_HI_OFS, 32'h8);
		bus(1'b1, ramp_pkg::LIM_LO_OFS, 32'h5);
		bus(1'b1, ramp_pkg::THRESH_OFS, 32'h3fffffff);
		bus(1'b1, ramp_pkg::STEP0_OFS, 32'h3);
		bus(1'b1, ramp_pkg::STEP1_OFS, 32'h3fffffff);
		bus(1'b1, ramp_pkg::CFG0_OFS, cfg(2, 0, 1, 0));
		bus(1'b1, ramp_pkg::CFG1_OFS, cfg(4, 1, 0, 0));
		for (i = 0; i < 10; i++) push_ofs(33'(v2[i]), g2[i]);
		bus(1'b1, ramp_pkg::CTRL_OFS, ctrl);
		drain("profiles");
		do_reset();
		bus(1'b1, ramp_pkg::LIM_HI_OFS, 32'hffffffff);
		bus(1'b1, ramp_pkg::THRESH_OFS, 32'h3fffffff);
		bus(1'b1, ramp_pkg::STEP0_OFS, 32'h1);
		bus(1'b1, ramp_pkg::CFG0_OFS,
			cfg(1, 0, 0, 0) | (32'h1 << ramp_pkg::CFG_TRIG_BIT));
		push_ofs(33'h1, 0);
		bus(1'b1, ramp_pkg::CTRL_OFS, ctrl);
		repeat (20) @(posedge CLK);
		cmp_flag(RAMP_ACTIVE === 1'b1 && RAMP_OFFSET === 33'h1,
			"no wait for trigger");
		rd(ramp_pkg::STATUS_OFS, 32'h3);
		push_ofs(33'h2, 0);
		TRIG <= 1'b1;
		drain("trigger");
		TRIG <= 1'b0;
		do_reset();
		bus(1'b1, ramp_pkg::LIM_HI_OFS, 32'hffffffff);
		bus(1'b1, ramp_pkg::THRESH_OFS, 32'h4);
		bus(1'b1, ramp_pkg::STEP0_OFS, 32'h3);
		bus(1'b1, ramp_pkg::CFG0_OFS, cfg(4, 0, 0, 1));
		for (i = 0; i < 7; i++) push_ofs(33'(v3[i]), g3[i]);
		bus(1'b1, ramp_pkg::CTRL_OFS, ctrl);
		drain("calibration");
		repeat (4) @(posedge CLK);
		cmp_flag(cal_n == 3, "calibration count");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
